// >>> gpb_pkg.sv
/*
 Package for the GPIO pad control bank: register offsets, reset values, widths.
 Assumes a classic Wishbone slave with 32-bit data, one aligned word per register.
*/
package gpb_pkg;
   // =====================================================================
   // Sizes
   localparam int unsigned NUM_PINS   = 24;
   localparam int unsigned LOW_PINS   = 16;
   localparam int unsigned HIGH_PINS  = 8;
   localparam int unsigned ADDR_W     = 12;
   // =====================================================================
   // Register indices, byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_DIR_LOW    = 12'h300;
   localparam logic [ADDR_W-1:0] IDX_DIR_HIGH   = 12'h302;
   localparam logic [ADDR_W-1:0] IDX_INEN_LOW   = 12'h304;
   localparam logic [ADDR_W-1:0] IDX_INEN_HIGH  = 12'h306;
   localparam logic [ADDR_W-1:0] IDX_PULL_LOW   = 12'h308;
   localparam logic [ADDR_W-1:0] IDX_PULL_HIGH  = 12'h30a;
   localparam logic [ADDR_W-1:0] IDX_LEVEL_LOW  = 12'h30c;
   localparam logic [ADDR_W-1:0] IDX_LEVEL_HIGH = 12'h30e;
   localparam logic [ADDR_W-1:0] IDX_RISE_LOW   = 12'h310;
   localparam logic [ADDR_W-1:0] IDX_RISE_HIGH  = 12'h312;
   localparam logic [ADDR_W-1:0] IDX_IRQ_LOW    = 12'h318;
   localparam logic [ADDR_W-1:0] IDX_IRQ_HIGH   = 12'h31a;
   localparam logic [ADDR_W-1:0] IDX_MASK_LOW   = 12'h320;
   localparam logic [ADDR_W-1:0] IDX_MASK_HIGH  = 12'h322;
   // =====================================================================
   // Reset values
   localparam logic [NUM_PINS-1:0] RST_DIR   = 24'h000000;
   localparam logic [NUM_PINS-1:0] RST_INEN  = 24'h000000;
   localparam logic [NUM_PINS-1:0] RST_PULL  = 24'h00ffff;
   localparam logic [NUM_PINS-1:0] RST_LEVEL = 24'h000000;
   localparam logic [NUM_PINS-1:0] RST_RISE  = 24'h000000;
   localparam logic [NUM_PINS-1:0] RST_IRQ   = 24'h000000;
   localparam logic [NUM_PINS-1:0] RST_MASK  = 24'h000000;
endpackage : gpb_pkg

// >>> gpb_bank.sv
/*
 GPIO pad control bank: 24 pins with direction, input enable, pull-down,
 pin level, rising-edge interrupt and mask registers behind classic Wishbone.
 Assumes pin inputs are synchronous to mclk_i and the pad applies the
 pull-down and input-enable outputs.
*/
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module gpb_bank #(
   parameter int unsigned NPIN = gpb_pkg::NUM_PINS
) (
   // Clock and reset
   input  wire logic                 mclk_i,
   input  wire logic                 rst_i,
   // Wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [13:0]          wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   // Pins
   input  wire logic [NPIN-1:0]      pin_n_i,
   output logic      [NPIN-1:0]      pin_n_o,
   output logic      [NPIN-1:0]      pin_n_oe_n_o,
   output logic      [NPIN-1:0]      pin_n_ie_o,
   output logic      [NPIN-1:0]      pin_n_pd_o,
   // Interrupt
   output logic                      irq_o
);
   // =====================================================================
   // Register storage
   logic [NPIN-1:0] dir_q, inen_q, pull_q, level_q, rise_q, irq_q, mask_q;
   logic [NPIN-1:0] pin_prev_q, rise_evt;
   logic [NPIN-1:0] irq_clr;
   logic            req, wr_acc, unmapped;
   logic [11:0]     idx;
   logic [31:0]     rd_d;

   assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign idx    = wb_adr_i[13:2];
   assign wr_acc = req & wb_we_i & wb_sel_i[0] & wb_sel_i[1];

   // Merge a low or high half write into a 24-bit register
   function automatic logic [NPIN-1:0] merge(input logic [NPIN-1:0] cur, input logic hi,
                                             input logic [15:0] wd);
      logic [NPIN-1:0] r;
      r = cur;
      if (hi) begin
         r[NPIN-1:16] = wd[NPIN-17:0];
      end else begin
         r[15:0] = wd;
      end
      return r;
   endfunction : merge

   function automatic logic hit(input logic [11:0] a, input logic [11:0] lo);
      return (a == lo) || (a == lo + 12'h002);
   endfunction : hit

   // =====================================================================
   // Configuration registers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         dir_q  <= gpb_pkg::RST_DIR;
         inen_q <= gpb_pkg::RST_INEN;
         pull_q <= gpb_pkg::RST_PULL;
         rise_q <= gpb_pkg::RST_RISE;
         mask_q <= gpb_pkg::RST_MASK;
      end else if (wr_acc) begin
         if (hit(idx, gpb_pkg::IDX_DIR_LOW))
            dir_q <= merge(dir_q, idx[1], wb_dat_i[15:0]);
         if (hit(idx, gpb_pkg::IDX_INEN_LOW))
            inen_q <= merge(inen_q, idx[1], wb_dat_i[15:0]);
         if (hit(idx, gpb_pkg::IDX_PULL_LOW))
            pull_q <= merge(pull_q, idx[1], wb_dat_i[15:0]);
         if (hit(idx, gpb_pkg::IDX_RISE_LOW))
            rise_q <= merge(rise_q, idx[1], wb_dat_i[15:0]);
         if (hit(idx, gpb_pkg::IDX_MASK_LOW))
            mask_q <= merge(mask_q, idx[1], wb_dat_i[15:0]);
      end
   end

   // =====================================================================
   // Output level register
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         level_q <= gpb_pkg::RST_LEVEL;
      end else if (wr_acc && hit(idx, gpb_pkg::IDX_LEVEL_LOW)) begin
         level_q <= merge(level_q, idx[1], wb_dat_i[15:0]);
      end
   end

   // =====================================================================
   // Pad drive
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pin_n_o      <= '0;
         pin_n_oe_n_o <= '1;
         pin_n_ie_o   <= '0;
         pin_n_pd_o   <= gpb_pkg::RST_PULL;
      end else begin
         pin_n_o      <= level_q;
         pin_n_oe_n_o <= ~dir_q;
         pin_n_ie_o   <= inen_q;
         pin_n_pd_o   <= pull_q;
      end
   end

   // =====================================================================
   // Rising-edge interrupts
   assign rise_evt = pin_n_i & ~pin_prev_q & rise_q & inen_q;
   assign irq_clr  = (wr_acc && hit(idx, gpb_pkg::IDX_IRQ_LOW)) ?
                     merge('0, idx[1], wb_dat_i[15:0]) : '0;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pin_prev_q <= '0;
         irq_q      <= gpb_pkg::RST_IRQ;
         irq_o      <= 1'b0;
      end else begin
         pin_prev_q <= pin_n_i;
         irq_q      <= (irq_q & ~irq_clr) | rise_evt;
         irq_o      <= |(((irq_q & ~irq_clr) | rise_evt) & mask_q);
      end
   end

   // =====================================================================
   // Read mux
   function automatic logic [15:0] half(input logic [NPIN-1:0] v, input logic hi);
      return hi ? {8'h00, v[NPIN-1:16]} : v[15:0];
   endfunction : half

   always_comb begin
      logic [NPIN-1:0] lvl;
      lvl      = (dir_q & level_q) | (~dir_q & inen_q & pin_n_i);
      rd_d     = 32'h00000000;
      unmapped = 1'b0;
      if (hit(idx, gpb_pkg::IDX_DIR_LOW))
         rd_d[15:0] = half(dir_q, idx[1]);
      else if (hit(idx, gpb_pkg::IDX_INEN_LOW))
         rd_d[15:0] = half(inen_q, idx[1]);
      else if (hit(idx, gpb_pkg::IDX_PULL_LOW))
         rd_d[15:0] = half(pull_q, idx[1]);
      else if (hit(idx, gpb_pkg::IDX_LEVEL_LOW))
         rd_d[15:0] = half(lvl, idx[1]);
      else if (hit(idx, gpb_pkg::IDX_RISE_LOW))
         rd_d[15:0] = half(rise_q, idx[1]);
      else if (hit(idx, gpb_pkg::IDX_IRQ_LOW))
         rd_d[15:0] = half(irq_q, idx[1]);
      else if (hit(idx, gpb_pkg::IDX_MASK_LOW))
         rd_d[15:0] = half(mask_q, idx[1]);
      else
         unmapped = 1'b1;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req && !unmapped) ? rd_d : 32'h00000000;
      end
   end

   // =====================================================================
   // Checks
   a_inen_reset: assert property (@(posedge mclk_i) rst_i |=> inen_q == '0)
      else $error("input enable not clear after reset");
   a_dir_reset: assert property (@(posedge mclk_i) rst_i |=> dir_q == '0 && pin_n_oe_n_o == '1)
      else $error("direction not input after reset");
   a_pull_reset: assert property (@(posedge mclk_i) rst_i |=> pull_q[15:0] == 16'hffff)
      else $error("low pull-down reset wrong");
   a_level_reset: assert property (@(posedge mclk_i) rst_i |=> level_q == '0)
      else $error("status reset wrong");
   a_ie_follow: assert property (@(posedge mclk_i) disable iff (rst_i) ##1 pin_n_ie_o == $past(inen_q))
      else $error("input enable not driven to pad");
   a_pd_follow: assert property (@(posedge mclk_i) disable iff (rst_i) ##1 pin_n_pd_o == $past(pull_q))
      else $error("pull-down not driven to pad");
   a_out_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_LEVEL_LOW |-> ##2 pin_n_o[15:0] == $past(wb_dat_i[15:0], 2))
      else $error("output level not driven");
   a_rise_set: assert property (@(posedge mclk_i) disable iff (rst_i)
      rise_evt[0] |=> irq_q[0])
      else $error("rising edge lost");
   a_rise_off: assert property (@(posedge mclk_i) disable iff (rst_i)
      !rise_q[0] && !irq_q[0] |=> !irq_q[0])
      else $error("disabled edge raised interrupt");
   a_high_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
      wb_ack_o && $past(idx[1]) |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper bits not zero");
   a_irq_out: assert property (@(posedge mclk_i) disable iff (rst_i)
      ##1 irq_o == |(irq_q & $past(mask_q)))
      else $error("interrupt output wrong");
   a_pd_reset: assert property (@(posedge mclk_i) rst_i |=> pin_n_pd_o == gpb_pkg::RST_PULL)
      else $error("pad pull-down reset wrong");
   a_ie_reset: assert property (@(posedge mclk_i) rst_i |=> pin_n_ie_o == '0)
      else $error("pad input enable reset wrong");
   a_irq_reset: assert property (@(posedge mclk_i) rst_i |=> !irq_o && irq_q == '0)
      else $error("interrupt reset wrong");
   a_ack_reset: assert property (@(posedge mclk_i) rst_i |=> !wb_ack_o)
      else $error("ack during reset");

   // =====================================================================
   // Bus handshake checks
   a_ack_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property (@(posedge mclk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   a_ack_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_unmap_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
      wb_ack_o && $past(unmapped) |-> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
      wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_sel_ignore: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && wb_we_i && !(wb_sel_i[0] && wb_sel_i[1]) |=>
      $stable(dir_q) && $stable(inen_q) && $stable(pull_q) && $stable(level_q) && $stable(rise_q) && $stable(mask_q))
      else $error("partial write changed a register");
   a_read_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && !wb_we_i |=>
      $stable(dir_q) && $stable(inen_q) && $stable(pull_q) && $stable(level_q) && $stable(rise_q) && $stable(mask_q))
      else $error("read changed a register");
   a_unmap_wr: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && unmapped |=>
      $stable(dir_q) && $stable(inen_q) && $stable(pull_q) && $stable(level_q) && $stable(rise_q) && $stable(mask_q))
      else $error("unmapped write changed a register");

   // =====================================================================
   // Register write checks
   a_dir_wlow: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_DIR_LOW |=> dir_q[15:0] == $past(wb_dat_i[15:0]))
      else $error("direction low write lost");
   a_dir_whigh: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_DIR_HIGH |=> dir_q[NPIN-1:16] == $past(wb_dat_i[NPIN-17:0]))
      else $error("direction high write lost");
   a_inen_wlow: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_INEN_LOW |=> inen_q[15:0] == $past(wb_dat_i[15:0]))
      else $error("input enable low write lost");
   a_inen_whigh: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_INEN_HIGH |=> inen_q[NPIN-1:16] == $past(wb_dat_i[NPIN-17:0]))
      else $error("input enable high write lost");
   a_pull_wlow: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_PULL_LOW |=> pull_q[15:0] == $past(wb_dat_i[15:0]))
      else $error("pull-down low write lost");
   a_pull_whigh: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_PULL_HIGH |=> pull_q[NPIN-1:16] == $past(wb_dat_i[NPIN-17:0]))
      else $error("pull-down high write lost");
   a_level_wlow: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_LEVEL_LOW |=> level_q[15:0] == $past(wb_dat_i[15:0]))
      else $error("level low write lost");
   a_level_whigh: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_LEVEL_HIGH |=> level_q[NPIN-1:16] == $past(wb_dat_i[NPIN-17:0]))
      else $error("level high write lost");
   a_rise_wlow: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_RISE_LOW |=> rise_q[15:0] == $past(wb_dat_i[15:0]))
      else $error("rise enable low write lost");
   a_rise_whigh: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_RISE_HIGH |=> rise_q[NPIN-1:16] == $past(wb_dat_i[NPIN-17:0]))
      else $error("rise enable high write lost");
   a_mask_wlow: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_MASK_LOW |=> mask_q[15:0] == $past(wb_dat_i[15:0]))
      else $error("mask low write lost");
   a_mask_whigh: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_MASK_HIGH |=> mask_q[NPIN-1:16] == $past(wb_dat_i[NPIN-17:0]))
      else $error("mask high write lost");
   a_high_ignore: assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_acc && idx == gpb_pkg::IDX_PULL_HIGH |=> pull_q[15:0] == $past(pull_q[15:0]))
      else $error("high write touched low pins");

   // =====================================================================
   // Register read checks
   a_dir_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && !wb_we_i && idx == gpb_pkg::IDX_DIR_LOW |=> wb_dat_o[15:0] == $past(dir_q[15:0]))
      else $error("direction read wrong");
   a_inen_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && !wb_we_i && idx == gpb_pkg::IDX_INEN_LOW |=> wb_dat_o[15:0] == $past(inen_q[15:0]))
      else $error("input enable read wrong");
   a_pull_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && !wb_we_i && idx == gpb_pkg::IDX_PULL_LOW |=> wb_dat_o[15:0] == $past(pull_q[15:0]))
      else $error("pull-down read wrong");
   a_rise_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && !wb_we_i && idx == gpb_pkg::IDX_RISE_LOW |=> wb_dat_o[15:0] == $past(rise_q[15:0]))
      else $error("rise enable read wrong");
   a_mask_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && !wb_we_i && idx == gpb_pkg::IDX_MASK_LOW |=> wb_dat_o[15:0] == $past(mask_q[15:0]))
      else $error("mask read wrong");
   a_irq_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && !wb_we_i && idx == gpb_pkg::IDX_IRQ_LOW |=> wb_dat_o[15:0] == $past(irq_q[15:0]))
      else $error("interrupt status read wrong");
   a_out_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && !wb_we_i && idx == gpb_pkg::IDX_LEVEL_LOW && dir_q[0] |=> wb_dat_o[0] == $past(level_q[0]))
      else $error("output pin status read wrong");
   a_in_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      req && !wb_we_i && idx == gpb_pkg::IDX_LEVEL_LOW && !dir_q[0] && inen_q[0] |=>
      wb_dat_o[0] == $past(pin_n_i[0]))
      else $error("input pin status read wrong");

   // =====================================================================
   // Pad and interrupt checks
   a_oe_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
      ##1 pin_n_oe_n_o == ~$past(dir_q))
      else $error("output enable not driven to pad");
   a_out_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
      ##1 pin_n_o == $past(level_q))
      else $error("output level not following register");
   a_rise_low: assert property (@(posedge mclk_i) disable iff (rst_i)
      pin_n_i[0] && !pin_prev_q[0] && rise_q[0] && inen_q[0] |=> irq_q[0])
      else $error("enabled rising edge on low pin lost");
   a_rise_high: assert property (@(posedge mclk_i) disable iff (rst_i)
      pin_n_i[16] && !pin_prev_q[16] && rise_q[16] && inen_q[16] |=> irq_q[16])
      else $error("enabled rising edge on high pin lost");
   a_irq_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
      irq_q[0] && !irq_clr[0] |=> irq_q[0])
      else $error("status bit not sticky");
   a_irq_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
      irq_clr[0] && !rise_evt[0] |=> !irq_q[0])
      else $error("status bit not cleared");
   a_irq_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
      !irq_q[0] && !rise_evt[0] |=> !irq_q[0])
      else $error("status bit set without event");
   a_irq_raise: assert property (@(posedge mclk_i) disable iff (rst_i)
      irq_q[0] && !irq_clr[0] && mask_q[0] |=> irq_o)
      else $error("unmasked status did not raise interrupt");
   a_irq_masked: assert property (@(posedge mclk_i) disable iff (rst_i)
      mask_q == '0 |=> !irq_o)
      else $error("interrupt raised while fully masked");
endmodule : gpb_bank

// >>> gpb_board.sv
/*
 Board model for the 24 pins of the pad bank.
 Assumes one clock shared with the bank; pins are resolved and registered on it.
*/
`timescale 1ns/10ps
module gpb_board (
   // Clock
   input  wire logic        mclk_i,
   // Bank side
   input  wire logic [23:0] bank_o_i,
   input  wire logic [23:0] bank_oe_n_i,
   input  wire logic [23:0] bank_pd_i,
   // Board drive
   input  wire logic [23:0] drv_en_i,
   input  wire logic [23:0] drv_val_i,
   output logic      [23:0] pin_o
);
   logic [23:0] flt_q = 24'h5a5a5a;
   logic [23:0] pin_q = 24'h000000;
   assign pin_o = pin_q;
   // =====================================================================
   // Pin level: bank drive, board drive, pull-down, else a toggling float
   always @(posedge mclk_i) begin
      flt_q <= ~flt_q;
      pin_q <= (~bank_oe_n_i & bank_o_i) | (bank_oe_n_i & drv_en_i & drv_val_i) |
               (bank_oe_n_i & ~drv_en_i & ~bank_pd_i & flt_q);
   end
endmodule : gpb_board

// >>> gpb_bank_test.sv
/*
 Self-checking bench for the pad bank over classic Wishbone.
 Assumes the bank answers every request with a one-cycle ack.
*/
`timescale 1ns/10ps
module gpb_bank_test;
   logic        mclk_i   = 1'b0;
   logic        rst_i    = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i  = 1'b0;
   logic [13:0] wb_adr_i = 14'h0000;
   logic [3:0]  wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        irq_o;
   logic [23:0] pin_n_i, pin_n_o, pin_n_oe_n_o, pin_n_ie_o, pin_n_pd_o;
   logic [23:0] drv_en   = 24'h0;
   logic [23:0] drv_val  = 24'h0;
   logic [31:0] seed     = 32'h4f77b922;
   logic [31:0] exp_q[$];
   logic [31:0] v;
   int          err_total = 0;
   int          n_checks  = 0;
   always #2.5 mclk_i = ~mclk_i;
   gpb_bank dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_n_i(pin_n_i), .pin_n_o(pin_n_o),
      .pin_n_oe_n_o(pin_n_oe_n_o), .pin_n_ie_o(pin_n_ie_o), .pin_n_pd_o(pin_n_pd_o), .irq_o(irq_o));
   gpb_board brd_u (.mclk_i(mclk_i), .bank_o_i(pin_n_o), .bank_oe_n_i(pin_n_oe_n_o),
      .bank_pd_i(pin_n_pd_o), .drv_en_i(drv_en), .drv_val_i(drv_val), .pin_o(pin_n_i));
   // =====================================================================
   // Helpers
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic we, input logic [11:0] idx, input logic [31:0] d);
      @(posedge mclk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= d;
      do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic rd(input logic [11:0] idx, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, idx, 32'h0);
   endtask : rd
   task automatic stop_test();
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   // =====================================================================
   // Read data monitor
   always @(posedge mclk_i)
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) chk("rdata", wb_dat_o, exp_q.pop_front());
   initial begin
      #50000;
      err_total++;
      stop_test();
   end
   // =====================================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1;
      chk("pd", {8'h0, pin_n_pd_o}, {8'h0, gpb_pkg::RST_PULL});
      chk("oe_n", {8'h0, pin_n_oe_n_o}, 32'hffffff);
      chk("ie", {8'h0, pin_n_ie_o}, 32'h0);
      rd(gpb_pkg::IDX_PULL_LOW, 32'hffff);
      rd(gpb_pkg::IDX_LEVEL_LOW, 32'h0);
      rd(gpb_pkg::IDX_LEVEL_HIGH, 32'h0);
      rd(gpb_pkg::IDX_DIR_LOW, 32'h0);
      rd(gpb_pkg::IDX_INEN_HIGH, 32'h0);
      rd(gpb_pkg::IDX_RISE_LOW, 32'h0);
      rd(12'h3ff, 32'h0);
      v = xs();
      bus(1'b1, gpb_pkg::IDX_PULL_LOW, v);
      bus(1'b1, gpb_pkg::IDX_PULL_HIGH, {v[31:16], v[31:16]});
      wb_sel_i <= 4'h1;
      bus(1'b1, gpb_pkg::IDX_PULL_LOW, ~v);
      wb_sel_i <= 4'hf;
      rd(gpb_pkg::IDX_PULL_LOW, {16'h0, v[15:0]});
      rd(gpb_pkg::IDX_PULL_HIGH, {24'h0, v[23:16]});
      chk("pd", {8'h0, pin_n_pd_o}, {8'h0, v[23:0]});
      bus(1'b1, gpb_pkg::IDX_DIR_LOW, 32'hffff);
      bus(1'b1, gpb_pkg::IDX_DIR_HIGH, 32'hff);
      v = xs();
      bus(1'b1, gpb_pkg::IDX_LEVEL_LOW, v);
      bus(1'b1, gpb_pkg::IDX_LEVEL_HIGH, v >> 16);
      rd(gpb_pkg::IDX_LEVEL_LOW, {16'h0, v[15:0]});
      chk("oe_n", {8'h0, pin_n_oe_n_o}, 32'h0);
      chk("out", {8'h0, pin_n_o}, {8'h0, v[23:0]});
      bus(1'b1, gpb_pkg::IDX_DIR_LOW, 32'h0);
      bus(1'b1, gpb_pkg::IDX_DIR_HIGH, 32'h0);
      bus(1'b1, gpb_pkg::IDX_INEN_LOW, 32'hffff);
      bus(1'b1, gpb_pkg::IDX_INEN_HIGH, 32'hff);
      v = xs();
      drv_en  <= 24'hffffff;
      drv_val <= v[23:0];
      repeat (4) @(posedge mclk_i);
      rd(gpb_pkg::IDX_LEVEL_LOW, {16'h0, v[15:0]});
      rd(gpb_pkg::IDX_LEVEL_HIGH, {24'h0, v[23:16]});
      chk("ie", {8'h0, pin_n_ie_o}, 32'hffffff);
      drv_val <= 24'h0;
      bus(1'b1, gpb_pkg::IDX_RISE_LOW, 32'h0008);
      bus(1'b1, gpb_pkg::IDX_MASK_LOW, 32'h0008);
      bus(1'b1, gpb_pkg::IDX_IRQ_LOW, 32'hffff);
      drv_val <= 24'h000018;
      repeat (6) @(posedge mclk_i);
      chk("irq", {31'h0, irq_o}, 32'h1);
      rd(gpb_pkg::IDX_IRQ_LOW, 32'h0008);
      bus(1'b1, gpb_pkg::IDX_IRQ_LOW, 32'h0008);
      rd(gpb_pkg::IDX_IRQ_LOW, 32'h0);
      chk("irq", {31'h0, irq_o}, 32'h0);
      bus(1'b1, gpb_pkg::IDX_MASK_LOW, 32'h0);
      drv_val <= 24'h0;
      repeat (4) @(posedge mclk_i);
      drv_val <= 24'h000008;
      repeat (6) @(posedge mclk_i);
      chk("irq", {31'h0, irq_o}, 32'h0);
      rd(gpb_pkg::IDX_IRQ_LOW, 32'h0008);
      @(posedge mclk_i);
      stop_test();
   end
endmodule : gpb_bank_test
